// ---- verilog/ebpwm_top.sv ----
// enhanced bridge pwm: timebase, duty compare, half/full bridge steering
// assumes clk_i is the oscillator clock; one instruction cycle is 4 clocks
// Summary of operation
// - period match clears timebase, sets output unless duty is zero
// - period end copies duty into shadow
// - postscaler never affects pwm period
// - duty is eight high plus two low bits
// - duty writes anytime; shadow is read-only
// - clear when shadow equals extended timebase
// - duty beyond period keeps output high
// - two-bit field picks four output arrangements
// - single mode behaves as standard pwm
// - period is 4*(period+1)*prescale clocks
// - high time is duty*prescale clocks
// - prescale selects 1, 4 or 16
// - half bridge: a pwm, b complement
// - dead band delays activation by count cycles
// - dead band beyond duty keeps output inactive
// - full bridge: two outputs active only
// - direction change applies next period
// - reversal: b,d off, a,c swap early
// - no dead band in full bridge
// - settings load at period start only
// - dead band only on rising activation
// - polarity per a/c and b/d pair
module ebpwm_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bridge outputs
    output logic output_a_o,
    output logic output_b_o,
    output logic output_c_o,
    output logic output_d_o,
    // timebase period-end pulse for the postscaler
    output logic period_end_o
);
    // registers written by software
    logic [7:0] period_register;
    logic [7:0] duty_write_register;
    logic [7:0] module_control_register;
    logic [7:0] timebase_control_register;
    logic [7:0] pwm_config_register;
    // timebase
    logic [1:0] qclk;
    logic [3:0] pre_cnt;
    logic [7:0] pwm_timebase;
    logic [1:0] ps_sel;
    ebpwm_pkg::ebpwm_shadow_s sh;
    logic pwm_raw;
    logic [8:0] db_clk;
    logic prev_raw;
    ebpwm_pkg::ebpwm_out_s act;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land at the edge that shows ack to the master
    wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire [7:0] wr_byte = wb_dat_i[7:0];
    wire sel_period = {1'b0, ebpwm_pkg::ADDR_PERIOD} == wb_adr_i;
    wire sel_duty = {1'b0, ebpwm_pkg::ADDR_DUTY} == wb_adr_i;
    wire sel_ctrl = {1'b0, ebpwm_pkg::ADDR_CTRL} == wb_adr_i;
    wire sel_tbctl = {1'b0, ebpwm_pkg::ADDR_TBCTL} == wb_adr_i;
    wire sel_cfg = ebpwm_pkg::ADDR_CFG5 == wb_adr_i;
    wire sel_shadow = ebpwm_pkg::ADDR_SHADOW == wb_adr_i;
    wire sel_status = ebpwm_pkg::ADDR_STATUS == wb_adr_i;
    wire [7:0] rd_byte = sel_period ? period_register :
                         sel_duty ? duty_write_register :
                         sel_ctrl ? module_control_register :
                         sel_tbctl ? timebase_control_register :
                         sel_cfg ? pwm_config_register :
                         sel_shadow ? sh.duty[9:2] :
                         sel_status ? {pwm_timebase} : 8'h00;
    wire [31:0] next_rd = {24'h000000, rd_byte};

    // prescale factor: 1, 4 or 16 instruction cycles per count
    wire [3:0] ps_max = (ps_sel == 2'h0) ? 4'h0 :
                        (ps_sel == 2'h1) ? 4'h3 : 4'hf;
    wire inst_end = qclk == ebpwm_pkg::QMAX;
    wire tick = inst_end && pre_cnt == ps_max;
    wire pmatch = pwm_timebase == period_register;
    wire new_period = tick & pmatch;
    wire [9:0] next_duty = {duty_write_register,
        module_control_register[ebpwm_pkg::CTRL_DLO_HI:ebpwm_pkg::CTRL_DLO_LO]};
    // low two bits: quarter clock for prescale 1, prescaler low bits for 4, prescaler top bits for 16
    wire [1:0] ext_lo = (ps_sel == 2'h0) ? qclk : pre_cnt[3:2] & {2{ps_sel != 2'h1}} | pre_cnt[1:0] & {2{ps_sel == 2'h1}};
    wire [9:0] ext_tb = {pwm_timebase, ext_lo};
    wire duty_hit = ext_tb == sh.duty;
    // output drops in the match cycle itself, so high time is exact
    wire pwm_eff = pwm_raw & ~duty_hit;
    wire [1:0] cfg_next = module_control_register[ebpwm_pkg::CTRL_MODE_LO +: 2];
    wire [1:0] pol_next = module_control_register[ebpwm_pkg::CTRL_POL_BD:ebpwm_pkg::CTRL_POL_AC];
    wire [6:0] dband_next = pwm_config_register[6:0];
    wire [1:0] ps_next = timebase_control_register[ebpwm_pkg::TB_PS_HI:ebpwm_pkg::TB_PS_LO];
    wire full_now = sh.mode == ebpwm_pkg::EBPWM_FWD || sh.mode == ebpwm_pkg::EBPWM_REV;
    wire full_next = module_control_register[ebpwm_pkg::CTRL_MODE_LO] == 1'b1;
    // last prescaled count before period end
    wire rev_pending = full_now && full_next &&
        module_control_register[ebpwm_pkg::CTRL_DIR +: 1] != sh.mode[1] && pmatch;
    wire rise = pwm_eff & ~prev_raw;
    wire fall = ~pwm_eff & prev_raw;
    wire [8:0] db_elapsed = (rise || fall) ? 9'h000 : db_clk;
    wire db_ok = db_elapsed >= {sh.dband, 2'h0};

    // output steering per mode
    always_comb begin
        act = '0;
        case (sh.mode)
            ebpwm_pkg::EBPWM_SINGLE: begin
                act.a = pwm_eff;
            end
            ebpwm_pkg::EBPWM_HALF: begin
                act.a = pwm_eff & db_ok;
                act.b = ~pwm_eff & db_ok;
            end
            ebpwm_pkg::EBPWM_FWD: begin
                act.a = ~rev_pending;
                act.c = rev_pending;
                act.d = pwm_eff & ~rev_pending;
            end
            ebpwm_pkg::EBPWM_REV: begin
                act.c = ~rev_pending;
                act.a = rev_pending;
                act.b = pwm_eff & ~rev_pending;
            end
            default: act = '0;
        endcase
    end
    // polarity: bit set drives the pair active-low
    wire pol_ac = sh.pol[ebpwm_pkg::CTRL_POL_AC];
    wire pol_bd = sh.pol[ebpwm_pkg::CTRL_POL_BD];

    // wishbone registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            period_register <= ebpwm_pkg::PERIOD_RST;
            duty_write_register <= ebpwm_pkg::ZERO8;
            module_control_register <= ebpwm_pkg::ZERO8;
            timebase_control_register <= ebpwm_pkg::ZERO8;
            pwm_config_register <= ebpwm_pkg::ZERO8;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= next_rd;
            // duty writes never touch the running period; shadow is read-only
            if (bus_wr && sel_period) period_register <= wr_byte;
            if (bus_wr && sel_duty) duty_write_register <= wr_byte;
            if (bus_wr && sel_ctrl) module_control_register <= wr_byte;
            if (bus_wr && sel_tbctl) timebase_control_register <= wr_byte;
            if (bus_wr && sel_cfg) pwm_config_register <= wr_byte;
        end
    end

    // timebase and duty compare
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qclk <= 2'h0;
            pre_cnt <= 4'h0;
            pwm_timebase <= 8'h00;
            ps_sel <= 2'h0;
            sh <= '0;
            pwm_raw <= 1'b0;
            period_end_o <= 1'b0;
        end else begin
            qclk <= qclk + 2'h1;
            period_end_o <= new_period;
            if (inst_end) pre_cnt <= (pre_cnt == ps_max) ? 4'h0 : pre_cnt + 4'h1;
            if (new_period) begin
                pwm_timebase <= 8'h00;
                // all settings latched together at the boundary
                sh.duty <= next_duty;
                sh.mode <= cfg_next;
                sh.pol <= pol_next;
                sh.dband <= dband_next;
                ps_sel <= ps_next;
                pwm_raw <= next_duty != 10'h000;
            end else begin
                if (tick) pwm_timebase <= pwm_timebase + 8'h01;
                if (duty_hit) pwm_raw <= 1'b0;
            end
        end
    end

    // dead band: clocks since the last pwm edge, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_raw <= 1'b0;
            db_clk <= 9'h000;
        end else begin
            prev_raw <= pwm_eff;
            if (rise || fall) db_clk <= 9'h001;
            else if (db_clk != 9'h1ff) db_clk <= db_clk + 9'h001;
        end
    end

    // registered pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_a_o <= 1'b0;
            output_b_o <= 1'b0;
            output_c_o <= 1'b0;
            output_d_o <= 1'b0;
        end else begin
            output_a_o <= act.a ^ pol_ac;
            output_c_o <= act.c ^ pol_ac;
            output_b_o <= act.b ^ pol_bd;
            output_d_o <= act.d ^ pol_bd;
        end
    end

    // checks
    AST_PERIOD_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> pwm_timebase == 8'h00)
        else $error("timebase not cleared at period end");
    AST_ZERO_DUTY: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period && next_duty == 10'h000 |=> !pwm_raw)
        else $error("output set with zero duty");
    AST_SHADOW_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> sh.duty == $past(next_duty))
        else $error("duty not copied to shadow");
    AST_SHADOW_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !new_period |=> $stable(sh))
        else $error("shadow changed mid period");
    AST_DUTY_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        duty_hit && !new_period |=> !pwm_raw)
        else $error("output not cleared at duty match");
    AST_PRESCALE: assert property (@(posedge clk_i) disable iff (rst_i)
        tick |-> qclk == 2'h3 && pre_cnt == ps_max)
        else $error("timebase advanced off prescale");
    AST_FULL_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_FWD |-> !act.b && (act.a != act.c))
        else $error("full bridge forward drives wrong outputs");
    AST_SINGLE_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_SINGLE |-> !act.b && !act.c && !act.d)
        else $error("single mode drives unused output");
    AST_HALF_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_HALF |-> !(act.a && act.b))
        else $error("half bridge both active");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // bus checks
    AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged");

    AST_ACK_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        !bus_req |=> !wb_ack_o)
        else $error("ack without request");

    AST_DUTY_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && sel_duty |=> duty_write_register == $past(wr_byte))
        else $error("duty write lost");

    AST_DUTY_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        !(bus_wr && sel_duty) |=> $stable(duty_write_register))
        else $error("duty register changed without write");

    AST_SHADOW_RO: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && sel_shadow && !new_period |=> $stable(sh))
        else $error("shadow written by bus");

    // timebase checks
    AST_TB_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && !pmatch |=> pwm_timebase == $past(pwm_timebase) + 8'h01)
        else $error("timebase did not advance");

    AST_TB_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick |=> $stable(pwm_timebase))
        else $error("timebase moved between ticks");

    AST_PE_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> period_end_o)
        else $error("period end pulse missing");

    AST_PE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        !new_period |=> !period_end_o)
        else $error("stray period end pulse");

    AST_PS_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && ps_sel == 2'h0 |-> pre_cnt == 4'h0)
        else $error("prescale one wrong");

    AST_PS_FOUR: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && ps_sel == 2'h1 |-> pre_cnt == 4'h3)
        else $error("prescale four wrong");

    AST_PS_SIXTEEN: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && ps_sel[1] |-> pre_cnt == 4'hf)
        else $error("prescale sixteen wrong");

    // period boundary loads
    AST_SET_NONZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period && next_duty != 10'h000 |=> pwm_raw)
        else $error("output not set at period start");

    AST_KEEP_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        pwm_raw && !duty_hit && !new_period |=> pwm_raw)
        else $error("output cleared without duty match");

    AST_MODE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> sh.mode == $past(cfg_next))
        else $error("configuration not loaded");

    AST_POL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> sh.pol == $past(pol_next))
        else $error("polarity not loaded");

    AST_DB_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> sh.dband == $past(dband_next))
        else $error("dead band not loaded");

    AST_PS_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        new_period |=> ps_sel == $past(ps_next))
        else $error("prescale not loaded");

    AST_PS_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !new_period |=> $stable(ps_sel))
        else $error("prescale changed mid period");

    // steering checks
    AST_SINGLE_A: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_SINGLE |-> act.a == pwm_eff)
        else $error("single output not pwm");

    AST_HALF_A: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_HALF && act.a |-> pwm_eff)
        else $error("half bridge a active while pwm low");

    AST_HALF_B: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_HALF && act.b |-> !pwm_eff)
        else $error("half bridge b active while pwm high");

    AST_HALF_CD: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_HALF |-> !act.c && !act.d)
        else $error("half bridge drives c or d");

    AST_DB_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_HALF && (rise || fall) && sh.dband != 7'h00 |-> !act.a && !act.b)
        else $error("dead band skipped");

    AST_DB_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_HALF && pwm_eff && db_elapsed >= {sh.dband, 2'h0} |-> act.a)
        else $error("a not driven after dead band");

    AST_FULL_REV: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_REV |-> !act.d && (act.a != act.c))
        else $error("full bridge reverse drives wrong outputs");

    AST_NO_DB_FWD: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_FWD && !rev_pending |-> act.d == pwm_eff)
        else $error("forward d delayed");

    AST_NO_DB_REV: assert property (@(posedge clk_i) disable iff (rst_i)
        sh.mode == ebpwm_pkg::EBPWM_REV && !rev_pending |-> act.b == pwm_eff)
        else $error("reverse b delayed");

    AST_SWAP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        rev_pending |-> !act.b && !act.d)
        else $error("modulated output active in swap");

    AST_SWAP_FWD: assert property (@(posedge clk_i) disable iff (rst_i)
        rev_pending && sh.mode == ebpwm_pkg::EBPWM_FWD |-> act.c && !act.a)
        else $error("forward swap wrong");

    AST_SWAP_REV: assert property (@(posedge clk_i) disable iff (rst_i)
        rev_pending && sh.mode == ebpwm_pkg::EBPWM_REV |-> act.a && !act.c)
        else $error("reverse swap wrong");
endmodule // ebpwm_top

// ---- verilog/ebpwm_pkg.sv ----
// package for the enhanced bridge pwm: register map, fields, modes, timing
// assumes a classic wishbone slave with 32-bit data, byte addresses
package ebpwm_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_PERIOD = 4'h0;
    localparam logic [3:0] ADDR_DUTY = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_TBCTL = 4'hc;
    localparam logic [4:0] ADDR_CFG = 5'h10;
    localparam logic [4:0] ADDR_SHADOW = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;
    localparam logic [4:0] ADDR_CFG5 = 5'h10;
    // module control register fields
    localparam int CTRL_DIR = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_DLO_HI = 5;
    localparam int CTRL_DLO_LO = 4;
    localparam int CTRL_POL_BD = 1;
    localparam int CTRL_POL_AC = 0;
    // timebase control fields
    localparam int TB_PS_HI = 1;
    localparam int TB_PS_LO = 0;
    // reset values
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [7:0] ZERO8 = 8'h00;
    // quarter-cycle count: one instruction cycle is four oscillator periods
    localparam logic [1:0] QMAX = 2'h3;
    // output configuration codes
    typedef enum logic [1:0] {
        EBPWM_SINGLE = 2'h0,
        EBPWM_HALF = 2'h2,
        EBPWM_FWD = 2'h1,
        EBPWM_REV = 2'h3
    } ebpwm_mode_e;
    // per-period shadowed settings
    typedef struct packed {
        logic [9:0] duty;
        logic [1:0] mode;
        logic [1:0] pol;
        logic [6:0] dband;
    } ebpwm_shadow_s;
    // bridge outputs, active-high before polarity
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ebpwm_out_s;
endpackage

// ---- bench/ebpwm_gate_model.sv ----
// gate driver model of a two-leg bridge: a/b first leg, c/d second leg
// assumes pin levels arrive as driven, pol_i tells which pairs are active low
module ebpwm_gate_model (
    // clock and pins
    input wire logic clk_i,
    input wire logic [3:0] pin_i,
    input wire logic [1:0] pol_i,
    // cycles with both switches of one leg on
    output int short_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] sw_on;
    assign sw_on = pin_i ^ {pol_i[0], pol_i[1], pol_i[0], pol_i[1]};
    initial short_o = 0;
    always @(posedge clk_i) begin
        if ((sw_on[3] && sw_on[2]) || (sw_on[1] && sw_on[0])) begin
            short_o <= short_o + 1;
        end
    end
endmodule // ebpwm_gate_model

// ---- bench/ebpwm_top_bench.sv ----
// self-checking bench: bus access, period and high-time counts, bridge modes
// assumes one instruction cycle is four clk_i cycles and a one-cycle ack
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module ebpwm_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [1:0] SGL = ebpwm_pkg::EBPWM_SINGLE;
    localparam logic [1:0] HLF = ebpwm_pkg::EBPWM_HALF;
    localparam logic [1:0] FWD = ebpwm_pkg::EBPWM_FWD;
    localparam logic [1:0] REV = ebpwm_pkg::EBPWM_REV;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h00000000, rdat, dat_o;
    logic ack, a, b, c, d, pe;
    logic [1:0] pol = 2'h0;
    logic [3:0] pins;
    int fail_count = 0, check_count = 0, cyc_n = 0, shorts, sh0, per, hi[4];
    assign pins = {a, b, c, d};
    ebpwm_top u_ebpwm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .output_a_o(a), .output_b_o(b), .output_c_o(c), .output_d_o(d), .period_end_o(pe));
    ebpwm_gate_model u_ebpwm_gate_model (.clk_i(clk_i), .pin_i(pins), .pol_i(pol), .short_o(shorts));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= {24'h000000, v};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic sync;
        int n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (pe !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            fail_count++;
            end_of_test();
        end
    endtask
    // clocks and high levels from one period end to the next
    task automatic span;
        per = 0;
        hi = '{0, 0, 0, 0};
        sh0 = shorts;
        do begin
            @(negedge clk_i);
            per++;
            foreach (hi[i]) hi[i] += pins[i];
        end while (pe !== 1'b1 && per < 2000);
        if (per >= 2000) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic check4(input int ep, input int ea, input int eb, input int ec, input int ed);
        int ex[4];
        ex = '{ed, ec, eb, ea};
        `CHK("period clocks", ep, per)
        `CHK("leg short cycles", 0, shorts - sh0)
        foreach (ex[i]) if (ex[i] >= 0) `CHK("high clocks", ex[i], hi[i])
    endtask
    // settings take hold at a boundary; measure the third full period after it
    task automatic run(input logic [9:0] dt, input logic [1:0] m, input logic [1:0] pl, input logic [6:0] db,
        input logic [1:0] ps, input int ep, input int ea, input int eb, input int ec, input int ed);
        bus(1'b1, 5'(ebpwm_pkg::ADDR_PERIOD), 8'h03);
        bus(1'b1, 5'(ebpwm_pkg::ADDR_DUTY), dt[9:2]);
        bus(1'b1, 5'(ebpwm_pkg::ADDR_CTRL), {m, dt[1:0], 2'h0, pl});
        bus(1'b1, ebpwm_pkg::ADDR_CFG5, {1'b0, db});
        bus(1'b1, 5'(ebpwm_pkg::ADDR_TBCTL), {6'h00, ps});
        pol = pl;
        sync();
        sync();
        sync();
        span();
        check4(ep, ea, eb, ec, ed);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 5'(ebpwm_pkg::ADDR_PERIOD), 8'h00);
        `CHK("period reset", 32'h000000ff, rdat)
        bus(1'b1, 5'h1c, 8'h5a);
        bus(1'b0, 5'h1c, 8'h00);
        `CHK("unmapped read", 32'h00000000, rdat)
        run(10'h006, SGL, 2'h0, 7'h00, 2'h0, 16, 6, 0, 0, 0);
        bus(1'b1, ebpwm_pkg::ADDR_SHADOW, 8'h77);
        bus(1'b0, ebpwm_pkg::ADDR_SHADOW, 8'h00);
        `CHK("shadow duty", 32'h00000001, rdat)
        // duty rewritten mid-period: old value until the boundary
        sync();
        fork
            span();
            bus(1'b1, 5'(ebpwm_pkg::ADDR_DUTY), 8'h02);
        join
        check4(16, 6, 0, 0, 0);
        span();
        check4(16, 10, 0, 0, 0);
        run(10'h000, SGL, 2'h0, 7'h00, 2'h0, 16, 0, 0, 0, 0);
        run(10'h050, SGL, 2'h0, 7'h00, 2'h0, 16, 16, 0, 0, 0);
        run(10'h006, SGL, 2'h0, 7'h00, 2'h1, 64, 24, 0, 0, 0);
        run(10'h006, SGL, 2'h0, 7'h00, 2'h2, 256, 96, 0, 0, 0);
        run(10'h006, SGL, 2'h3, 7'h00, 2'h0, 16, 10, 16, 16, 16);
        run(10'h006, HLF, 2'h0, 7'h01, 2'h0, 16, 2, 6, -1, -1);
        run(10'h006, HLF, 2'h0, 7'h03, 2'h0, 16, 0, 0, -1, -1);
        run(10'h006, FWD, 2'h0, 7'h01, 2'h0, 16, 16, 0, 0, 6);
        run(10'h006, REV, 2'h0, 7'h01, 2'h0, 16, 0, 6, 16, 0);
        // reversal at moderate duty; the last count turns b,d off and swaps a,c early
        sync();
        fork
            span();
            bus(1'b1, 5'(ebpwm_pkg::ADDR_CTRL), {FWD, 2'h2, 4'h0});
        join
        check4(16, 4, 6, 12, 0);
        span();
        check4(16, 16, 0, 0, 6);
        end_of_test();
    end
endmodule // ebpwm_top_bench
